/* inc/unam_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants for unit number area mapping
package unam_pkg;
  localparam int unsigned UNIT_NUM_W      = 7;      // Selector width
  localparam int unsigned UNIT_MAX        = 95;     // Highest legal unit number
  localparam int unsigned WORD_ADDR_W     = 16;     // Host word address width
  localparam int unsigned REFRESH_BASE    = 2000;   // Refresh window base word
  localparam int unsigned REFRESH_STRIDE  = 10;     // Refresh words per unit
  localparam int unsigned FIXED_BASE      = 20000;  // Data-memory window base word
  localparam int unsigned FIXED_STRIDE    = 100;    // Data-memory words per unit
  localparam int unsigned RESTART_WORD0   = 502;    // Word holding restart bit of unit 0
  localparam int unsigned RESTART_BITS_W  = 16;     // Restart bits per word
  localparam int unsigned RESTART_IDX_W   = 4;      // Bit index width in a word
  localparam int unsigned DATA_W          = 16;     // Host word width
  typedef enum logic [3:0] {
    UNAM_ST_SAMPLE = 4'h1,  // Catch selector after reset
    UNAM_ST_LOAD   = 4'h2,  // Read fixed data words
    UNAM_ST_RUN    = 4'h4,  // Exchange refresh words
    UNAM_ST_BADNUM = 4'h8   // Selector out of range
  } unam_state_e;
endpackage
`default_nettype wire

/* logic/unam_restart_detect.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Restart bit edge tracker: pulse once the bit falls after a set
module unam_restart_detect (
  input  wire logic clk_sys_i,     // System clock
  input  wire logic rst_i,         // Sync reset, high
  input  wire logic bit_i,         // Selected restart bit
  output logic      restart_o      // One-cycle pulse on on-then-off
);
  logic armed_reg;                 // Bit has been seen on
  logic armed_next;
  logic pulse_reg;                 // Registered restart pulse
  logic pulse_next;

  // ==========================================================
  // Next state: arm on high, fire on fall
  always_comb begin
    armed_next = armed_reg;
    pulse_next = 1'b0;
    if (bit_i) begin
      // Wait for release, a lone set does nothing
      armed_next = 1'b1;
    end else if (armed_reg) begin
      armed_next = 1'b0;
      pulse_next = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      pulse_reg <= pulse_next;
    end
  end

  assign restart_o = pulse_reg;
endmodule
`default_nettype wire

/* logic/unam_area_map.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Refresh window exchanged every refresh cycle while running, except on a restart cycle
// - Fixed data read only at reset/restart
// - Refresh base is 2000 plus ten n
// - Data window base 20000 plus hundred n
// - Unit numbers zero to 95 accepted
// - Restart bit on then off restarts unit while running
// - Restart bits from word 502, 16 per word
module unam_area_map #(
  parameter int unsigned FIXED_WORDS = 10   // Fixed data words loaded per restart
) (
  input  wire logic                         clk_sys_i,       // System clock
  input  wire logic                         rst_i,           // Sync reset, high
  input  wire logic [unam_pkg::UNIT_NUM_W-1:0] unit_sel_i,   // Front selector
  input  wire logic                         refresh_i,       // Host refresh cycle strobe
  input  wire logic [unam_pkg::DATA_W-1:0]  restart_word_i,  // Host restart word
  input  wire logic [unam_pkg::DATA_W-1:0]  rd_data_i,       // Word read back from host
  input  wire logic                         rd_valid_i,      // Read data valid
  output logic [unam_pkg::WORD_ADDR_W-1:0]  restart_addr_o,  // Word holding our restart bit
  output logic [unam_pkg::RESTART_IDX_W-1:0] restart_bit_o,  // Bit index within it
  output logic                              fixed_rd_o,      // Fixed data read request
  output logic [unam_pkg::WORD_ADDR_W-1:0]  fixed_addr_o,    // Fixed data word address
  output logic                              refresh_go_o,    // Refresh exchange pulse
  output logic [unam_pkg::WORD_ADDR_W-1:0]  refresh_base_o,  // First refresh word
  output logic                              cfg_we_o,        // Fixed word write to unit
  output logic [7:0]                        cfg_idx_o,       // Fixed word index
  output logic [unam_pkg::DATA_W-1:0]       cfg_data_o,      // Fixed word value
  output logic                              running_o,       // Unit in operation
  output logic                              bad_unit_o       // Selector out of range
);
  // ==========================================================
  // Parameter check
  // The load may not run past the unit's own data-memory window
  if (FIXED_WORDS < 1 || FIXED_WORDS > unam_pkg::FIXED_STRIDE) begin : g_bad_words
    $error("FIXED_WORDS must lie in 1..window size");
  end

  // ==========================================================
  // Address decoding helpers
  // Sums are formed at 32 bits, then cut to the host address width
  function automatic logic [unam_pkg::WORD_ADDR_W-1:0] refresh_base(
    input logic [unam_pkg::UNIT_NUM_W-1:0] n);
    refresh_base = unam_pkg::WORD_ADDR_W'(unam_pkg::REFRESH_BASE
                   + unam_pkg::REFRESH_STRIDE * n);
  endfunction

  function automatic logic [unam_pkg::WORD_ADDR_W-1:0] fixed_addr(
    input logic [unam_pkg::UNIT_NUM_W-1:0] n, input logic [7:0] k);
    fixed_addr = unam_pkg::WORD_ADDR_W'(unam_pkg::FIXED_BASE
                 + unam_pkg::FIXED_STRIDE * n + k);
  endfunction

  // ==========================================================
  // State
  // One-hot state plus the values held for the host
  unam_pkg::unam_state_e state_reg, state_next;
  logic [unam_pkg::UNIT_NUM_W-1:0]   unit_reg, unit_next;       // Held unit number
  logic [7:0]                        idx_reg, idx_next;         // Load word counter
  logic                              pend_reg, pend_next;       // Read outstanding
  logic                              rd_reg, rd_next;           // Read request pulse
  logic [unam_pkg::WORD_ADDR_W-1:0]  faddr_reg, faddr_next;     // Read address
  logic                              go_reg, go_next;           // Refresh exchange pulse
  logic [unam_pkg::WORD_ADDR_W-1:0]  rbase_reg, rbase_next;     // Refresh window base
  logic                              we_reg, we_next;           // Config write pulse
  logic [7:0]                        cidx_reg, cidx_next;       // Config word index
  logic [unam_pkg::DATA_W-1:0]       cdata_reg, cdata_next;     // Config word value
  logic [unam_pkg::WORD_ADDR_W-1:0]  raddr_reg, raddr_next;     // Restart word address
  logic [unam_pkg::RESTART_IDX_W-1:0] rbit_reg, rbit_next;      // Restart bit index
  logic                              run_reg, run_next;         // Unit in operation
  logic                              bad_reg, bad_next;         // Selector out of range
  logic                              restart_pulse;             // From edge tracker
  logic                              sel_bit;                   // Our restart bit

  // ==========================================================
  // Restart bit tracking
  // Index comes from the held number, so a moved switch cannot retarget it
  // Pick our bit out of the restart word
  assign sel_bit = restart_word_i[rbit_reg];

  unam_restart_detect u_restart (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .bit_i     (sel_bit),
    .restart_o (restart_pulse)
  );

  // ==========================================================
  // Next state logic
  // Pulses default low; every other register holds
  always_comb begin
    state_next = state_reg;
    unit_next  = unit_reg;
    idx_next   = idx_reg;
    pend_next  = pend_reg;
    rd_next    = 1'b0;
    faddr_next = faddr_reg;
    go_next    = 1'b0;
    rbase_next = rbase_reg;
    we_next    = 1'b0;
    cidx_next  = cidx_reg;
    cdata_next = cdata_reg;
    raddr_next = raddr_reg;
    rbit_next  = rbit_reg;
    case (state_reg)
      unam_pkg::UNAM_ST_SAMPLE: begin
        // Selector caught once here, never again until reset
        unit_next  = unit_sel_i;
        rbase_next = refresh_base(unit_sel_i);
        // Restart word is the base plus n/16, bit is n mod 16
        raddr_next = unam_pkg::WORD_ADDR_W'(unam_pkg::RESTART_WORD0
                     + unit_sel_i / unam_pkg::RESTART_BITS_W);
        rbit_next  = unit_sel_i[unam_pkg::RESTART_IDX_W-1:0];
        idx_next   = 8'h00;
        pend_next  = 1'b0;
        // Out-of-range numbers stop here rather than decode a stray window
        if (unit_sel_i > unam_pkg::UNIT_NUM_W'(unam_pkg::UNIT_MAX)) begin
          state_next = unam_pkg::UNAM_ST_BADNUM;
        end else begin
          state_next = unam_pkg::UNAM_ST_LOAD;
        end
      end
      unam_pkg::UNAM_ST_LOAD: begin
        // Fixed data fetched only in this state
        // One read in flight, no timeout: a silent host stalls the load
        if (!pend_reg) begin
          rd_next    = 1'b1;
          faddr_next = fixed_addr(unit_reg, idx_reg);
          pend_next  = 1'b1;
        end else if (rd_valid_i) begin
          // Word lands in the unit's settings store
          we_next    = 1'b1;
          cidx_next  = idx_reg;
          cdata_next = rd_data_i;
          pend_next  = 1'b0;
          if (idx_reg == 8'(FIXED_WORDS - 1)) begin
            state_next = unam_pkg::UNAM_ST_RUN;
          end else begin
            idx_next = idx_reg + 8'h01;
          end
        end
      end
      unam_pkg::UNAM_ST_RUN: begin
        // Restart wins over a refresh strobe in the same cycle
        if (restart_pulse) begin
          // Reload settings, keep the held unit number
          idx_next   = 8'h00;
          pend_next  = 1'b0;
          state_next = unam_pkg::UNAM_ST_LOAD;
        end else if (refresh_i) begin
          go_next = 1'b1;
        end
      end
      unam_pkg::UNAM_ST_BADNUM: begin
        // Stuck until reset; a restart cannot fix a bad selector
        // The switch must be set right and the unit reset
        state_next = unam_pkg::UNAM_ST_BADNUM;
      end
      default: begin
        state_next = unam_pkg::UNAM_ST_SAMPLE;
      end
    endcase
    // Flags follow the next state, so each output leaves a flip-flop
    run_next = (state_next == unam_pkg::UNAM_ST_RUN);
    bad_next = (state_next == unam_pkg::UNAM_ST_BADNUM);
  end

  // ==========================================================
  // Registers only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= unam_pkg::UNAM_ST_SAMPLE;
      unit_reg  <= '0;
      idx_reg   <= 8'h00;
      pend_reg  <= 1'b0;
      rd_reg    <= 1'b0;
      faddr_reg <= '0;
      go_reg    <= 1'b0;
      rbase_reg <= '0;
      we_reg    <= 1'b0;
      cidx_reg  <= 8'h00;
      cdata_reg <= '0;
      raddr_reg <= '0;
      rbit_reg  <= '0;
      run_reg   <= 1'b0;
      bad_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      unit_reg  <= unit_next;
      idx_reg   <= idx_next;
      pend_reg  <= pend_next;
      rd_reg    <= rd_next;
      faddr_reg <= faddr_next;
      go_reg    <= go_next;
      rbase_reg <= rbase_next;
      we_reg    <= we_next;
      cidx_reg  <= cidx_next;
      cdata_reg <= cdata_next;
      raddr_reg <= raddr_next;
      rbit_reg  <= rbit_next;
      run_reg   <= run_next;
      bad_reg   <= bad_next;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  // Pulses last one cycle; addresses hold until the next change
  assign restart_addr_o = raddr_reg;
  assign restart_bit_o  = rbit_reg;
  assign fixed_rd_o     = rd_reg;
  assign fixed_addr_o   = faddr_reg;
  assign refresh_go_o   = go_reg;
  assign refresh_base_o = rbase_reg;
  assign cfg_we_o       = we_reg;
  assign cfg_idx_o      = cidx_reg;
  assign cfg_data_o     = cdata_reg;
  assign running_o      = run_reg;
  assign bad_unit_o     = bad_reg;
endmodule
`default_nettype wire

/* dv/unam_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker for the area map
module unam_asserts #(
  parameter int unsigned FIXED_WORDS = 10  // Words per load
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [6:0]  unit_sel_i,
  input wire logic        refresh_i,
  input wire logic [15:0] restart_word_i,
  input wire logic        rd_valid_i,
  input wire logic [15:0] restart_addr_o,
  input wire logic [3:0]  restart_bit_o,
  input wire logic        fixed_rd_o,
  input wire logic [15:0] fixed_addr_o,
  input wire logic        refresh_go_o,
  input wire logic [15:0] refresh_base_o,
  input wire logic        cfg_we_o,
  input wire logic        running_o,
  input wire logic        bad_unit_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [6:0] n_reg, n_next;  // Unit number caught once
  logic       arm_reg, arm_next;  // First edge after reset
  // Catch the selector as the design should
  always_comb begin
    arm_next = rst_i ? 1'b1 : 1'b0;
    n_next   = (arm_reg && !rst_i) ? unit_sel_i : n_reg;
  end
  always_ff @(posedge clk_sys_i) begin
    arm_reg <= arm_next;
    n_reg   <= n_next;
  end
  // Own restart bit goes on, then off
  sequence s_bit_fall;
    running_o && restart_word_i[restart_bit_o] ##1 running_o && !restart_word_i[restart_bit_o];
  endsequence
  a_cfg_after_read: assert property (cfg_we_o |-> $past(rd_valid_i))
    else $error("config write without read data");
  a_load_not_run: assert property (fixed_rd_o |-> !running_o)
    else $error("fixed read while running");
  a_refresh_cause: assert property (refresh_go_o |-> $past(refresh_i) && $past(running_o))
    else $error("refresh exchange without cause");
  a_refresh_base: assert property (running_o |-> refresh_base_o == 16'(2000 + 10 * n_reg))
    else $error("refresh base wrong");
  a_fixed_window: assert property (fixed_rd_o |->
    fixed_addr_o >= 20000 + 100 * n_reg && fixed_addr_o < 20000 + 100 * n_reg + FIXED_WORDS)
    else $error("fixed address outside window");
  a_restart_map: assert property (running_o |->
    restart_addr_o == 16'(502 + n_reg / 16) && restart_bit_o == 4'(n_reg % 16))
    else $error("restart bit location wrong");
  a_bad_range: assert property (bad_unit_o |-> n_reg > 95 && !running_o && !fixed_rd_o)
    else $error("bad unit flag wrong");
  a_restart_load: assert property (s_bit_fall |-> ##[1:3] !running_o ##[1:2] fixed_rd_o)
    else $error("restart did not reload");
  a_reset_quiet: assert property (@(posedge clk_sys_i) disable iff (1'b0)
    rst_i |=> !running_o && !fixed_rd_o && !cfg_we_o && !refresh_go_o)
    else $error("outputs active in reset");
endmodule
`default_nettype wire

/* dv/unam_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Host side: answers fixed data reads
module unam_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        slow_i,        // Answer two cycles later
  input  wire logic        fixed_rd_i,
  input  wire logic [15:0] fixed_addr_i,
  output logic [15:0]      rd_data_o,
  output logic             rd_valid_o
);
  logic [15:0] addr_reg;  // Word being read
  logic [2:0]  cnt_reg;   // Cycles to the answer
  initial begin
    rd_data_o  = 16'h0000;
    rd_valid_o = 1'b0;
    cnt_reg    = 3'h0;
  end
  // Word value is a fixed mix of its address
  always @(posedge clk_sys_i) begin
    if (fixed_rd_i) begin
      addr_reg = fixed_addr_i;
      cnt_reg  = slow_i ? 3'h3 : 3'h1;
    end
    #1;
    rd_valid_o = (cnt_reg == 3'h1);
    // Idle bus inverts each cycle, so the last word returns every second idle cycle
    rd_data_o = rd_valid_o ? (addr_reg ^ 16'h5A5A) : ~rd_data_o;
    if (cnt_reg != 3'h0) cnt_reg = cnt_reg - 3'h1;
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Bench: queued notes checked by monitor
module testbench;
  localparam int unsigned FW = 4;  // Short load keeps runs brief
  logic        clk_sys_i, rst_i, refresh_i, rd_valid_i, slow, fixed_rd_o;
  logic        refresh_go_o, cfg_we_o, running_o, bad_unit_o;
  logic [6:0]  unit_sel_i;
  logic [3:0]  restart_bit_o;
  logic [7:0]  cfg_idx_o;
  logic [15:0] restart_word_i, rd_data_i, restart_addr_o, fixed_addr_o, refresh_base_o, cfg_data_o;
  logic [24:0] notes[$], got;  // {kind, index, value}
  logic [15:0] m;
  int          n_fail, checks_done, cyc, n;
  integer      seed;  // Random stream state
  unam_area_map #(.FIXED_WORDS(FW)) uut (.clk_sys_i, .rst_i, .unit_sel_i, .refresh_i,
    .restart_word_i, .rd_data_i, .rd_valid_i, .restart_addr_o, .restart_bit_o, .fixed_rd_o,
    .fixed_addr_o, .refresh_go_o, .refresh_base_o, .cfg_we_o, .cfg_idx_o, .cfg_data_o,
    .running_o, .bad_unit_o);
  // One unit on this host, so no two units ever share a number
  unam_host_model host (.clk_sys_i, .slow_i(slow), .fixed_rd_i(fixed_rd_o),
    .fixed_addr_i(fixed_addr_o), .rd_data_o(rd_data_i), .rd_valid_o(rd_valid_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [24:0] g, input logic [24:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  // Expect one full fixed load for unit u
  task automatic load(input int u);
    for (int k = 0; k < FW; k++) notes.push_back({1'b0, 8'(k), 16'(20000 + 100 * u + k) ^ 16'h5A5A});
  endtask
  task automatic wait_run();
    for (int i = 0; i < 200 && running_o !== 1'b1; i++) tick(1);
    chk({24'h0, running_o}, 25'h1);
  endtask
  task automatic pulse(input logic go, input int u);
    if (go) notes.push_back({1'b1, 8'h00, 16'(2000 + 10 * u)});
    refresh_i = 1'b1;
    tick(1);
    refresh_i = 1'b0;
    tick(2);
  endtask
  task automatic boot(input int u);
    rst_i          = 1'b1;
    restart_word_i = 16'h0000;
    unit_sel_i     = 7'(u);
    tick(2);
    rst_i = 1'b0;
    if (u <= 95) load(u);
    tick(2);
  endtask
  // Monitor: each result takes the oldest note
  always @(posedge clk_sys_i) begin
    if (cfg_we_o === 1'b1 || refresh_go_o === 1'b1) begin
      got = cfg_we_o ? {1'b0, cfg_idx_o, cfg_data_o} : {1'b1, 8'h00, refresh_base_o};
      chk(got, notes.size() ? notes.pop_front() : 25'h1FFFFFF);
    end
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {refresh_i, slow, rst_i, restart_word_i, unit_sel_i} = '0;
    rst_i = 1'b1;
    seed  = 32'h4876;
    for (int t = 0; t < 5; t++) begin
      n = (t == 0) ? 0 : (t == 1) ? 95 : {$random(seed)} % 96;
      slow = t[0];
      boot(n);
      wait_run();
      chk({5'h0, restart_bit_o, restart_addr_o}, {5'h0, 4'(n % 16), 16'(502 + n / 16)});
      unit_sel_i = 7'($random(seed));
      pulse(1'b1, n);
      m = 16'h1 << (n % 16);
      restart_word_i = 16'($random(seed)) | m;
      tick(8);
      chk({24'h0, running_o}, 25'h1);
      load(n);
      restart_word_i = restart_word_i & ~m;
      tick(3);
      pulse(1'b0, n);
      wait_run();
      pulse(1'b1, n);
    end
    boot(96 + {$random(seed)} % 32);
    pulse(1'b0, 0);
    chk({23'h0, bad_unit_o, running_o}, 25'h2);
    tick(5);
    chk(25'(notes.size()), 25'h0);
    finish_test();
  end
endmodule
bind unam_area_map unam_asserts #(.FIXED_WORDS(FIXED_WORDS)) chk_i (.clk_sys_i, .rst_i,
  .unit_sel_i, .refresh_i, .restart_word_i, .rd_valid_i, .restart_addr_o, .restart_bit_o,
  .fixed_rd_o, .fixed_addr_o, .refresh_go_o, .refresh_base_o, .cfg_we_o, .running_o,
  .bad_unit_o);
`default_nettype wire
